// ---- event_poll_responder_regs.svh ----
// Constants of the event poll responder: codes, lengths, field slices and register offsets.
`ifndef EVENT_POLL_RESPONDER_REGS_SVH
`define EVENT_POLL_RESPONDER_REGS_SVH

// Request field values.
`define EVP_LAYOUT_VERSION  8'h01
`define EVP_OP_NEXT         8'h00
`define EVP_OP_FIRST        8'h01
`define EVP_OP_ACK          8'h02

// Result codes.
`define EVP_RC_SUCCESS      8'h00
`define EVP_RC_BAD_VERSION  8'h81
`define EVP_RC_BAD_EVENT    8'h82

// Special event numbers.
`define EVP_EVN_EMPTY       16'h0000
`define EVP_EVN_ACK_ONLY    16'hFFFF
`define EVP_EVN_FIRST       16'h0001
`define EVP_EVN_LAST        16'hFFFE

// Chunk position codes.
`define EVP_POS_START       8'h00
`define EVP_POS_MIDDLE      8'h01
`define EVP_POS_END         8'h04
`define EVP_POS_SINGLE      8'h05

// Request layout: eight bytes gathered into one 64-bit word, first byte lowest.
`define EVP_REQ_BYTES       4'h8
`define EVP_RQ_VER          7:0
`define EVP_RQ_OP           15:8
`define EVP_RQ_HANDLE       47:16
`define EVP_RQ_ACK          63:48

// Response lengths in bytes.
`define EVP_RESP_ERR        4'h1
`define EVP_RESP_SHORT      4'h4
`define EVP_RESP_FULL       4'hE

// Register byte offsets.
`define EVP_REG_CTRL        8'h00
`define EVP_REG_EVT_TOKEN   8'h04
`define EVP_REG_EVT_SIZE    8'h08
`define EVP_REG_EVT_INFO    8'h0C
`define EVP_REG_EVT_PUSH    8'h10
`define EVP_REG_STATUS      8'h14
`define EVP_REG_LAST_HANDLE 8'h18

// Register fields and reset values.
`define EVP_CTRL_TERMINUS   7:0
`define EVP_INFO_CAT        7:0
`define EVP_INFO_POS        15:8
`define EVP_TERMINUS_RST    8'h00
`define EVP_CAT_RST         8'h00

// Queue and buffer sizes.
`define EVP_QUEUE_DEPTH     4
`define EVP_FIFO_DEPTH      8

`endif

// ---- event_poll_responder_pkg.sv ----
// Types shared by the event poll responder.
package event_poll_responder_pkg;
    typedef enum logic [1:0] {
        S_RECV = 2'b00,
        S_EVAL = 2'b01,
        S_SEND = 2'b10
    } evp_state_t;
endpackage : event_poll_responder_pkg

// ---- event_poll_responder.sv ----
// Event poll responder: request parser, event queue, response framer and its output FIFO.
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`include "event_poll_responder_regs.svh"

// Shift-register FIFO: the head always sits in entry zero, so the outputs are flip-flops.
module evp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    output logic                  o_out_valid,
    output logic      [WIDTH-1:0] o_out_data,
    input  wire logic             i_out_ready
);
    localparam int CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [CW-1:0]    cnt_q;
    logic [CW-1:0]    cnt_d;
    logic             full_q;
    logic             push;
    logic             pop;

    // Push is honest about fullness; a pop in the same cycle does not make room, which keeps ready a flop.
    assign push        = i_in_valid && !full_q;
    assign pop         = o_out_valid && i_out_ready;
    assign cnt_d       = cnt_q + CW'(push) - CW'(pop);
    assign o_in_ready  = !full_q;
    assign o_out_data  = mem_q[0];

    // Count and flags.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q       <= '0;
            full_q      <= 1'b0;
            o_out_valid <= 1'b0;
        end else begin
            cnt_q       <= cnt_d;
            full_q      <= (cnt_d == CW'(DEPTH));
            o_out_valid <= (cnt_d != '0);
        end
    end

    // Each entry takes the one above it on a pop, or the new word when it is the write slot.
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        logic [WIDTH-1:0] above;
        assign above = (i == DEPTH - 1) ? mem_q[i] : mem_q[(i + 1) % DEPTH];
        always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                mem_q[i] <= '0;
            end else if (push && (cnt_q - CW'(pop)) == CW'(i)) begin
                mem_q[i] <= i_in_data;
            end else if (pop) begin
                mem_q[i] <= above;
            end
        end
    end
endmodule : evp_fifo

// Top: takes an 8-byte poll request, evaluates it against the event queue and frames the response.
module event_poll_responder (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wr_data,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rd_data,
    input  wire logic        i_req_valid,
    input  wire logic [7:0]  i_req_data,
    output logic             o_req_ready,
    output logic             o_resp_valid,
    output logic      [7:0]  o_resp_data,
    output logic             o_resp_last,
    input  wire logic        i_resp_ready
);
    import event_poll_responder_pkg::*;

    localparam int QD = `EVP_QUEUE_DEPTH;

    evp_state_t  state_q;
    logic [63:0] req_q;
    logic [3:0]  rx_cnt_q;
    logic [7:0]  terminus_q;
    logic [31:0] stage_tok_q;
    logic [31:0] stage_size_q;
    logic [7:0]  stage_cat_q;
    logic [7:0]  stage_pos_q;
    logic [15:0] next_num_q;
    logic [15:0] q_num_q  [QD];
    logic [31:0] q_tok_q  [QD];
    logic [31:0] q_size_q [QD];
    logic [7:0]  q_cat_q  [QD];
    logic [7:0]  q_pos_q  [QD];
    logic [1:0]  head_q;
    logic [2:0]  qcnt_q;
    logic [31:0] last_handle_q;
    logic [7:0]  res_q;
    logic [15:0] evn_q;
    logic [31:0] tok_q;
    logic [7:0]  pos_q;
    logic [7:0]  cat_q;
    logic [31:0] size_q;
    logic [3:0]  len_q;
    logic [3:0]  idx_q;

    // Request decode.
    logic [7:0]  rq_ver;
    logic [7:0]  rq_op;
    logic [15:0] rq_ack;
    logic        take_byte;
    logic        eval;
    logic        ver_ok;
    logic        ack_plain;
    logic        ack_hit;
    logic        ack_bad;
    logic        do_pop;
    logic        eval_ok;
    assign rq_ver    = req_q[`EVP_RQ_VER];
    assign rq_op     = req_q[`EVP_RQ_OP];
    assign rq_ack    = req_q[`EVP_RQ_ACK];
    assign take_byte = i_req_valid && o_req_ready;
    assign eval      = (state_q == S_EVAL);
    assign ver_ok    = (rq_ver == `EVP_LAYOUT_VERSION);
    // A zero ack asks for the first entry and an all-ones ack continues a transfer; neither deletes.
    assign ack_plain = (rq_ack != `EVP_EVN_EMPTY) && (rq_ack != `EVP_EVN_ACK_ONLY);
    assign ack_hit   = ack_plain && (qcnt_q != 3'h0) && (rq_ack == q_num_q[head_q]);
    assign ack_bad   = ack_plain && !ack_hit;
    assign eval_ok   = eval && ver_ok && !ack_bad;
    assign do_pop    = eval_ok && ack_hit;

    // Register bus decode; a push during a pop is absorbed by the shared count update below.
    logic        push;
    logic        q_full;
    logic [1:0]  tail;
    logic [1:0]  head_d;
    logic [2:0]  qcnt_d;
    assign push   = i_wr && (i_addr == `EVP_REG_EVT_PUSH);
    assign q_full = (qcnt_q == 3'(QD));
    assign tail   = head_q + qcnt_q[1:0];
    // When full, a new event overwrites the oldest one rather than being dropped.
    assign head_d = head_q + 2'(do_pop || (push && q_full));
    assign qcnt_d = (push && q_full && !do_pop) ? qcnt_q : qcnt_q + 3'(push) - 3'(do_pop);

    // State seen by the evaluation after any deletion.
    logic [1:0]  head_after;
    logic [2:0]  cnt_after;
    logic [15:0] evn_pick;
    logic [3:0]  len_pick;
    assign head_after = head_q + 2'(do_pop);
    assign cnt_after  = qcnt_q - 3'(do_pop);
    assign evn_pick   = (cnt_after == 3'h0) ? `EVP_EVN_EMPTY :
                        (rq_op == `EVP_OP_ACK) ? `EVP_EVN_ACK_ONLY :
                        q_num_q[head_after];
    assign len_pick   = !eval_ok ? `EVP_RESP_ERR :
                        (evn_pick == `EVP_EVN_EMPTY || evn_pick == `EVP_EVN_ACK_ONLY) ? `EVP_RESP_SHORT :
                        `EVP_RESP_FULL;

    // Response bytes in wire order, every multi-byte field low byte first.
    logic [111:0] resp_vec;
    logic [7:0]   resp_byte;
    logic         fifo_ready;
    logic         send_push;
    logic         send_last;
    assign resp_vec  = {size_q, cat_q, pos_q, tok_q, evn_q, terminus_q, res_q};
    assign resp_byte = resp_vec[{idx_q, 3'b000} +: 8];
    assign send_push = (state_q == S_SEND);
    assign send_last = (idx_q == len_q - 4'h1);

    // Sequencer: receive eight bytes, evaluate once, send the framed answer.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q     <= S_RECV;
            rx_cnt_q    <= 4'h0;
            idx_q       <= 4'h0;
            o_req_ready <= 1'b1;
        end else begin
            case (state_q)
                S_RECV: begin
                    if (take_byte && rx_cnt_q == `EVP_REQ_BYTES - 4'h1) begin
                        state_q     <= S_EVAL;
                        rx_cnt_q    <= 4'h0;
                        o_req_ready <= 1'b0;
                    end else if (take_byte) begin
                        rx_cnt_q <= rx_cnt_q + 4'h1;
                    end
                end
                S_EVAL: begin
                    state_q <= S_SEND;
                    idx_q   <= 4'h0;
                end
                S_SEND: begin
                    if (fifo_ready && send_last) begin
                        state_q     <= S_RECV;
                        o_req_ready <= 1'b1;
                    end else if (fifo_ready) begin
                        idx_q <= idx_q + 4'h1;
                    end
                end
                default: begin
                    state_q     <= S_RECV;
                    o_req_ready <= 1'b1;
                end
            endcase
        end
    end

    // Request bytes shift in from the top, so the first byte lands lowest.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            req_q <= '0;
        end else if (take_byte) begin
            req_q <= {i_req_data, req_q[63:8]};
        end
    end

    // Evaluation latches the answer; a failed request answers with its result code alone.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            res_q  <= `EVP_RC_SUCCESS;
            evn_q  <= `EVP_EVN_EMPTY;
            tok_q  <= '0;
            pos_q  <= `EVP_POS_START;
            cat_q  <= `EVP_CAT_RST;
            size_q <= '0;
            len_q  <= `EVP_RESP_ERR;
        end else if (eval) begin
            res_q  <= !ver_ok ? `EVP_RC_BAD_VERSION : ack_bad ? `EVP_RC_BAD_EVENT : `EVP_RC_SUCCESS;
            evn_q  <= evn_pick;
            tok_q  <= q_tok_q[head_after];
            pos_q  <= q_pos_q[head_after];
            cat_q  <= q_cat_q[head_after];
            size_q <= q_size_q[head_after];
            len_q  <= len_pick;
        end
    end

    // The handle only matters for next-chunk requests, so only those record it.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            last_handle_q <= '0;
        end else if (eval && rq_op == `EVP_OP_NEXT) begin
            last_handle_q <= req_q[`EVP_RQ_HANDLE];
        end
    end

    // Event queue pointers and number allocation; numbers skip zero and all-ones.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            head_q     <= 2'h0;
            qcnt_q     <= 3'h0;
            next_num_q <= `EVP_EVN_FIRST;
        end else begin
            head_q <= head_d;
            qcnt_q <= qcnt_d;
            if (push) begin
                next_num_q <= (next_num_q == `EVP_EVN_LAST) ? `EVP_EVN_FIRST : next_num_q + 16'h0001;
            end
        end
    end

    // Queue entries are written at the tail from the staging registers.
    always_ff @(posedge i_clk) begin
        if (push) begin
            q_num_q[tail]  <= next_num_q;
            q_tok_q[tail]  <= stage_tok_q;
            q_size_q[tail] <= stage_size_q;
            q_cat_q[tail]  <= stage_cat_q;
            q_pos_q[tail]  <= stage_pos_q;
        end
    end

    // Writable registers.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            terminus_q   <= `EVP_TERMINUS_RST;
            stage_tok_q  <= '0;
            stage_size_q <= '0;
            stage_cat_q  <= `EVP_CAT_RST;
            stage_pos_q  <= `EVP_POS_SINGLE;
        end else if (i_wr) begin
            case (i_addr)
                `EVP_REG_CTRL:      terminus_q   <= i_wr_data[`EVP_CTRL_TERMINUS];
                `EVP_REG_EVT_TOKEN: stage_tok_q  <= i_wr_data;
                `EVP_REG_EVT_SIZE:  stage_size_q <= i_wr_data;
                `EVP_REG_EVT_INFO: begin
                    stage_cat_q <= i_wr_data[`EVP_INFO_CAT];
                    stage_pos_q <= i_wr_data[`EVP_INFO_POS];
                end
                default: begin
                end
            endcase
        end
    end

    // Read mux; unmapped addresses read zero.
    logic [31:0] rd_mux;
    assign rd_mux = (i_addr == `EVP_REG_CTRL)        ? {24'h000000, terminus_q} :
                    (i_addr == `EVP_REG_EVT_TOKEN)   ? stage_tok_q :
                    (i_addr == `EVP_REG_EVT_SIZE)    ? stage_size_q :
                    (i_addr == `EVP_REG_EVT_INFO)    ? {16'h0000, stage_pos_q, stage_cat_q} :
                    (i_addr == `EVP_REG_EVT_PUSH)    ? {29'h0, qcnt_q} :
                    (i_addr == `EVP_REG_STATUS)      ? {next_num_q, res_q, 5'h00, qcnt_q} :
                    (i_addr == `EVP_REG_LAST_HANDLE) ? last_handle_q : 32'h00000000;

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rd_data <= '0;
        end else begin
            o_rd_data <= i_rd ? rd_mux : 32'h00000000;
        end
    end

    // Output buffer; its fullness stalls the sender, so a slow sink backs up to the request port.
    evp_fifo #(
        .WIDTH (9),
        .DEPTH (`EVP_FIFO_DEPTH)
    ) u_fifo (
        .i_clk       (i_clk),
        .i_rst_n     (i_rst_n),
        .i_in_valid  (send_push),
        .i_in_data   ({send_last, resp_byte}),
        .o_in_ready  (fifo_ready),
        .o_out_valid (o_resp_valid),
        .o_out_data  ({o_resp_last, o_resp_data}),
        .i_out_ready (i_resp_ready)
    );

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    empty_number_a: assert property (eval_ok && cnt_after == 3'h0 |=> evn_q == `EVP_EVN_EMPTY)
        else $error("Empty queue did not report event number zero.");
    ackonly_number_a: assert property (
        eval_ok && rq_op == `EVP_OP_ACK && cnt_after != 3'h0 |=> evn_q == `EVP_EVN_ACK_ONLY)
        else $error("Ack-only poll with events left did not report all-ones.");
    short_response_a: assert property (
        state_q == S_SEND && res_q == `EVP_RC_SUCCESS &&
        (evn_q == `EVP_EVN_EMPTY || evn_q == `EVP_EVN_ACK_ONLY) |-> len_q == `EVP_RESP_SHORT)
        else $error("Special event number sent with trailing fields.");
    bad_version_a: assert property (
        eval && !ver_ok |=> res_q == `EVP_RC_BAD_VERSION && len_q == `EVP_RESP_ERR && state_q == S_SEND)
        else $error("Wrong layout version not answered with its code.");
    bad_ack_a: assert property (eval && ver_ok && ack_bad |=> res_q == `EVP_RC_BAD_EVENT)
        else $error("Unknown acknowledged number not answered with its code.");
    ack_delete_a: assert property (do_pop && !push |=> qcnt_q == $past(qcnt_q) - 3'h1)
        else $error("Acknowledged event stayed in the queue.");
    handle_ignored_a: assert property (eval && rq_op != `EVP_OP_NEXT |=> $stable(last_handle_q))
        else $error("Chunk handle used on a request that must ignore it.");
    terminus_byte_a: assert property (send_push && idx_q == 4'h1 |-> resp_byte == terminus_q)
        else $error("Second response byte is not the terminus number.");
    number_low_first_a: assert property (
        send_push && fifo_ready && idx_q == 4'h2 |=> resp_byte == evn_q[15:8] || !fifo_ready)
        else $error("Event number not sent low byte first.");
    number_valid_a: assert property (push |-> next_num_q != `EVP_EVN_EMPTY && next_num_q != `EVP_EVN_ACK_ONLY)
        else $error("Event assigned a reserved number.");

    empty_poll_c: cover property (eval_ok && cnt_after == 3'h0);
    full_event_c: cover property (eval_ok && len_pick == `EVP_RESP_FULL ##[1:40] o_resp_last && o_resp_valid);
    ack_only_c: cover property (eval_ok && rq_op == `EVP_OP_ACK && do_pop);
    fifo_stall_c: cover property (send_push && !fifo_ready);
endmodule : event_poll_responder

// ---- mc_model.sv ----
// Management controller model: sends poll requests and collects response frames.
module controller_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    output logic            o_req_valid,
    output logic      [7:0] o_req_data,
    input  wire logic       i_req_ready,
    input  wire logic       i_resp_valid,
    input  wire logic [7:0] i_resp_data,
    input  wire logic       i_resp_last,
    output logic            o_resp_ready
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] rsp[$];
    int         frames = 0;
    bit         slow   = 1'b0;
    int         phase  = 0;

    // Request lines idle low from time zero.
    initial begin
        o_req_valid = 1'b0;
        o_req_data  = 8'h00;
    end

    // Bytes go out as version, operation, handle, ack number; fields least significant byte first.
    task automatic send_req(input logic [7:0] ver, input logic [7:0] op,
                            input logic [31:0] hdl, input logic [15:0] ack);
        logic [63:0] word;
        logic        rdy;
        word = {ack, hdl, op, ver};
        for (int i = 0; i < 8; i++) begin
            o_req_valid <= 1'b1;
            o_req_data  <= word[8*i +: 8];
            do begin
                @(negedge i_clk);
                rdy = i_req_ready;
                @(posedge i_clk);
            end while (!rdy);
        end
        // The released data line shows the inverse, so a stale byte never looks fresh.
        o_req_valid <= 1'b0;
        o_req_data  <= ~word[63:56];
    endtask : send_req

    // Slow mode takes a byte only every fourth cycle, so the output FIFO fills and stalls.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_resp_ready <= 1'b0;
            phase        <= 0;
        end else begin
            phase        <= phase + 1;
            o_resp_ready <= !slow || (phase % 4 == 0);
            if (i_resp_valid && o_resp_ready) begin
                rsp.push_back(i_resp_data);
                if (i_resp_last) begin
                    frames <= frames + 1;
                end
            end
        end
    end
endmodule : controller_model

// ---- event_poll_responder_bench.sv ----
// Bench for the event poll responder: register tasks, poll sequences and frame checks.
`include "event_poll_responder_regs.svh"
module event_poll_responder_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import event_poll_responder_pkg::*;

    logic        clk        = 1'b0;
    logic        rst_n      = 1'b0;
    logic [7:0]  addr       = 8'h00;
    logic [31:0] wr_data    = 32'h0;
    logic        wr         = 1'b0;
    logic        rd         = 1'b0;
    logic [31:0] rd_data;
    logic        req_valid;
    logic [7:0]  req_data;
    logic        req_ready;
    logic        resp_valid;
    logic [7:0]  resp_data;
    logic        resp_last;
    logic        resp_ready;
    logic [7:0]  term_num   = 8'h5A;
    logic [7:0]  pos_codes[4] = '{`EVP_POS_START, `EVP_POS_MIDDLE, `EVP_POS_END, `EVP_POS_SINGLE};
    int          fails      = 0;
    int          compares   = 0;
    int          cycles     = 0;

    event_poll_responder event_poll_responder_inst (
        .i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wr_data(wr_data), .i_wr(wr), .i_rd(rd),
        .o_rd_data(rd_data), .i_req_valid(req_valid), .i_req_data(req_data), .o_req_ready(req_ready),
        .o_resp_valid(resp_valid), .o_resp_data(resp_data), .o_resp_last(resp_last),
        .i_resp_ready(resp_ready)
    );

    controller_model controller_model_inst (
        .i_clk(clk), .i_rst_n(rst_n), .o_req_valid(req_valid), .o_req_data(req_data),
        .i_req_ready(req_ready), .i_resp_valid(resp_valid), .i_resp_data(resp_data),
        .i_resp_last(resp_last), .o_resp_ready(resp_ready)
    );

    // A 25 ns clock.
    always #12.5 clk = ~clk;

    task automatic complete_run();
        if (fails == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    // The whole run needs a few hundred cycles; the ceiling leaves a wide margin.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            complete_run();
        end
    end

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp8

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp32

    // An extra edge after each write keeps the strobe from being assigned twice in one step.
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        addr    <= a;
        wr_data <= d;
        wr      <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : reg_write

    // Read data stand only in the cycle after the strobe, so they are taken at its falling edge.
    task automatic check_reg(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        cmp32(rd_data & mask, exp);
        @(posedge clk);
    endtask : check_reg

    task automatic push_event(input logic [31:0] tok, input logic [31:0] sz, input logic [7:0] pos,
                              input logic [7:0] cat);
        reg_write(`EVP_REG_EVT_TOKEN, tok);
        reg_write(`EVP_REG_EVT_SIZE, sz);
        reg_write(`EVP_REG_EVT_INFO, {16'h0000, pos, cat});
        reg_write(`EVP_REG_EVT_PUSH, 32'h0);
    endtask : push_event

    // Sends one request and compares the whole reply, byte by byte, with the frame built here.
    task automatic poll(input logic [7:0] ver, input logic [7:0] op, input logic [31:0] hdl,
                        input logic [15:0] ack, input logic [7:0] rc, input logic [15:0] num,
                        input logic [31:0] tok, input logic [7:0] pos, input logic [7:0] cat,
                        input logic [31:0] sz);
        logic [111:0] frame;
        int           len;
        int           f0;
        frame = {sz, cat, pos, tok, num, term_num, rc};
        len   = (rc != `EVP_RC_SUCCESS) ? 1 : (num == 16'h0000 || num == 16'hFFFF) ? 4 : 14;
        f0    = controller_model_inst.frames;
        controller_model_inst.rsp.delete();
        controller_model_inst.send_req(ver, op, hdl, ack);
        for (int i = 0; i < 400 && controller_model_inst.frames == f0; i++) begin
            @(posedge clk);
        end
        cmp32(32'(controller_model_inst.rsp.size()), 32'(len));
        for (int i = 0; i < len && i < controller_model_inst.rsp.size(); i++) begin
            cmp8(controller_model_inst.rsp[i], frame[8*i +: 8]);
        end
    endtask : poll

    // Main sequence.
    initial begin
        logic [31:0] tok;
        logic [31:0] sz;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check_reg(`EVP_REG_CTRL, 32'h000000FF, 32'h0);
        check_reg(`EVP_REG_STATUS, 32'hFFFF0007, 32'h00010000);
        check_reg(8'h1C, 32'hFFFFFFFF, 32'h0);
        reg_write(`EVP_REG_CTRL, {24'h0, term_num});
        check_reg(`EVP_REG_CTRL, 32'h000000FF, {24'h0, term_num});
        poll(8'h01, `EVP_OP_FIRST, 32'hFFFFFFFF, 16'h0000, 8'h00, 16'h0000, 32'h0, 8'h0, 8'h0, 32'h0);
        poll(8'h02, `EVP_OP_FIRST, 32'h0, 16'h0000, 8'h81, 16'h0, 32'h0, 8'h0, 8'h0, 32'h0);
        // One event per chunk position code; every poll after the first acknowledges the one before it.
        for (int k = 0; k < 4; k++) begin
            controller_model_inst.slow = k[0];
            tok = 32'hA0B0C0D0 + 32'(k);
            sz  = 32'h10 + 32'(k);
            push_event(tok, sz, pos_codes[k], 8'h20 + 8'(k));
            poll(8'h01, `EVP_OP_FIRST, 32'hDEADBEEF, 16'(k), 8'h00, 16'(k + 1), tok, pos_codes[k],
                 8'h20 + 8'(k), sz);
        end
        check_reg(`EVP_REG_STATUS, 32'hFFFFFF07, 32'h00050001);
        poll(8'h01, `EVP_OP_ACK, 32'h0, 16'h0000, 8'h00, 16'hFFFF, 32'h0, 8'h0, 8'h0, 32'h0);
        poll(8'h01, `EVP_OP_FIRST, 32'h0, 16'h0007, 8'h82, 16'h0, 32'h0, 8'h0, 8'h0, 32'h0);
        check_reg(`EVP_REG_STATUS, 32'h0000FF07, 32'h00008201);
        poll(8'h01, `EVP_OP_NEXT, 32'h12345678, 16'hFFFF, 8'h00, 16'h0004, 32'hA0B0C0D3, 8'h05,
             8'h23, 32'h13);
        check_reg(`EVP_REG_LAST_HANDLE, 32'hFFFFFFFF, 32'h12345678);
        poll(8'h01, `EVP_OP_ACK, 32'hCAFEF00D, 16'h0004, 8'h00, 16'h0000, 32'h0, 8'h0, 8'h0, 32'h0);
        check_reg(`EVP_REG_LAST_HANDLE, 32'hFFFFFFFF, 32'h12345678);
        check_reg(`EVP_REG_STATUS, 32'h00000007, 32'h0);
        // Five pushes into a queue of four: the oldest is overwritten, so the head is the second one.
        for (int k = 0; k < 5; k++) begin
            push_event(32'h0C0C0000 + 32'(k), 32'h40 + 32'(k), `EVP_POS_MIDDLE, 8'h30 + 8'(k));
        end
        check_reg(`EVP_REG_STATUS, 32'hFFFFFF07, 32'h000A0004);
        poll(8'h01, `EVP_OP_FIRST, 32'h0, 16'h0000, 8'h00, 16'h0006, 32'h0C0C0001, `EVP_POS_MIDDLE, 8'h31,
             32'h41);
        complete_run();
    end
endmodule : event_poll_responder_bench
